/* File: dv/kacf_checker_asserts.sv */
`timescale 1ns/1ps
module kacf_sva
    import kacf_pkg::*;
(
    input wire logic          clk_sys,
    input wire logic          nrst,
    input wire kacf_byte_type rx_byte,
    input wire logic          rx_ready,
    input wire kacf_cond_type cond,
    input wire logic          needs_payload,
    input wire kacf_byte_type tx_byte,
    input wire logic          tx_ready,
    input wire logic          frame_done,
    input wire logic [7:0]    last_status
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic [5:0] rx_cnt_ff, nxt_rx_cnt, tx_cnt_ff, nxt_tx_cnt;
    logic       rx_end, tx_acc;
    // byte positions on both streams, so field values can be tied to offsets
    always_comb begin
        rx_end     = rx_byte.valid && rx_ready && (rx_cnt_ff == 6'h3F || rx_byte.last);
        tx_acc     = tx_byte.valid && tx_ready;
        nxt_rx_cnt = rx_end ? 6'h00 : rx_cnt_ff + 6'(rx_byte.valid && rx_ready);
        nxt_tx_cnt = (tx_acc && tx_byte.last) ? 6'h00 : tx_cnt_ff + 6'(tx_acc);
    end
    always_ff @(posedge clk_sys) begin
        rx_cnt_ff <= nrst ? nxt_rx_cnt : 6'h00;
        tx_cnt_ff <= nrst ? nxt_tx_cnt : 6'h00;
    end
    a_rst_clear: assert property ($rose(nrst) |-> tx_byte == '0 && !frame_done && last_status == 8'h00)
        else $error("outputs not cleared by reset");
    a_rx_stops: assert property (rx_end |=> !rx_ready)
        else $error("receive not closed after frame end");
    a_tx_starts: assert property (rx_end |-> ##[2:3] tx_byte.valid)
        else $error("response did not start in time");
    a_tx_holds: assert property (tx_byte.valid && !tx_ready |=> $stable(tx_byte))
        else $error("response byte changed while stalled");
    a_tx_preamble: assert property (tx_byte.valid && tx_cnt_ff < 2 |->
        tx_byte.data == (tx_cnt_ff == 0 ? 8'hA1 : 8'hEC)) else $error("bad response preamble");
    a_tx_revision: assert property (tx_byte.valid && tx_cnt_ff == 2 |-> tx_byte.data == 8'h03)
        else $error("bad response revision");
    a_status_byte: assert property (tx_byte.valid && tx_cnt_ff == 5 |-> tx_byte.data == last_status)
        else $error("status byte differs from result");
    a_zero_fields: assert property (tx_byte.valid && tx_cnt_ff inside {4, [6:61]} |-> tx_byte.data == 8'h00)
        else $error("unused response field not zero");
    a_last_pos: assert property (tx_byte.valid && tx_byte.last |-> tx_cnt_ff == 6'h3F)
        else $error("last flag off byte 63");
    a_done_pulse: assert property (frame_done |=> !frame_done)
        else $error("done longer than one cycle");
    a_no_deprecated: assert property (last_status != 8'h10)
        else $error("deprecated read code reported");
    c_short: cover property (rx_end && rx_cnt_ff != 6'h3F);
    c_stall: cover property (tx_byte.valid && !tx_ready);
    c_crc_bad: cover property (frame_done && last_status == 8'hFB);
endmodule
bind kacf_checker kacf_sva i_kacf_sva (.clk_sys(clk_sys), .nrst(nrst), .rx_byte(rx_byte), .rx_ready(rx_ready),
    .cond(cond), .needs_payload(needs_payload), .tx_byte(tx_byte), .tx_ready(tx_ready),
    .frame_done(frame_done), .last_status(last_status));

/* File: dv/kacf_host.sv */
`timescale 1ns/1ps
module kacf_host
    import kacf_pkg::*;
(
    input  wire logic          clk_sys,
    output      kacf_byte_type rx_byte,
    input  wire logic          rx_ready,
    input  wire kacf_byte_type tx_byte,
    output      logic          tx_ready
);
    logic [7:0] frm [64];
    logic [7:0] rsp [64];
    int         rsp_n;
    logic [7:0] protocol_revision_byte = 8'h03; // the bench may spoil it to reach the revision check
    initial begin
        rx_byte  = '0;
        tx_ready = 1'b0;
    end
    // header checksum, msb first, start zero
    function automatic logic [15:0] crc16(input logic [7:0] f [64]);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 2; i < 62; i++) begin
            c = c ^ {f[i], 8'h00};
            for (int b = 0; b < 8; b++) begin
                c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
            end
        end
        return c;
    endfunction
    // one command out, whole response back; n below 64 cuts the frame short
    task automatic xfer(input logic [7:0] cmd, input logic [31:0] len, input logic [31:0] pcrc,
                        input logic [15:0] err, input logic [7:0] pre, input int n);
        logic [15:0] c;
        for (int i = 0; i < 64; i++) begin
            frm[i] = 8'h5A; // junk in ignored bytes and flags, receiver must not care
        end
        frm[0] = pre;
        frm[1] = 8'hEC;
        frm[2] = protocol_revision_byte;
        frm[3] = cmd;
        for (int k = 0; k < 4; k++) begin
            frm[8+k]  = len[31-8*k -: 8];
            frm[58+k] = pcrc[31-8*k -: 8];
        end
        c = crc16(frm) ^ err;
        frm[62] = c[15:8];
        frm[63] = c[7:0];
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys);
            rx_byte = '{1'b1, i == n - 1, frm[i]};
            while (!rx_ready) @(negedge clk_sys);
        end
        @(negedge clk_sys);
        // released line must not look like a stale byte
        rx_byte = '{1'b0, 1'b0, ~rx_byte.data};
        rsp_n = 0;
        for (int t = 0; t < 400 && rsp_n < 64; t++) begin
            @(negedge clk_sys);
            // ready is decided first: the byte standing now is the one the coming rising edge takes
            tx_ready = (t % 5) != 3; // stall one cycle in five
            if (tx_byte.valid && tx_ready) begin
                rsp[rsp_n] = tx_byte.data;
                rsp_n++;
            end
        end
    endtask
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import kacf_pkg::*;
    logic          clk_sys = 1'b0;
    logic          nrst;
    kacf_byte_type rx_byte, tx_byte;
    kacf_cond_type cond;
    logic          needs_payload, rx_ready, tx_ready, frame_done;
    logic [7:0]    last_status;
    int            n_errors = 0;
    int            checks_done = 0;
    int            cycles = 0;
    int            n_done = 0;
    always #5 clk_sys = ~clk_sys;
    kacf_checker i_kacf_checker (.clk_sys(clk_sys), .nrst(nrst), .rx_byte(rx_byte), .rx_ready(rx_ready),
        .cond(cond), .needs_payload(needs_payload), .tx_byte(tx_byte), .tx_ready(tx_ready),
        .frame_done(frame_done), .last_status(last_status));
    kacf_host i_kacf_host (.clk_sys(clk_sys), .rx_byte(rx_byte), .rx_ready(rx_ready),
        .tx_byte(tx_byte), .tx_ready(tx_ready));
    task end_sim;
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // about fifteen frames of some 150 cycles each fit well inside this
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    // done pulses, counted at the falling edge where each one stands
    always @(negedge clk_sys) begin
        if (frame_done === 1'b1) n_done++;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one exchange, then the response's fixed fields, echo, status and checksums judged against the expected code
    task automatic run(input logic [7:0] cmd, input logic [31:0] len, input logic [31:0] pcrc,
                       input logic [15:0] err, input logic [7:0] pre, input int n, input logic [7:0] st);
        logic [7:0] r [64];
        int         d0;
        d0 = n_done;
        i_kacf_host.xfer(cmd, len, pcrc, err, pre, n);
        r = i_kacf_host.rsp;
        @(negedge clk_sys); // lets the pulse of the last byte be counted before it is judged
        chk("frame_done", 1, n_done - d0);
        chk("byte count", 64, i_kacf_host.rsp_n);
        chk("preamble", 16'hA1EC, {r[0], r[1]});
        chk("revision", 8'h03, r[2]);
        chk("command", cmd, r[3]);
        chk("status", st, r[5]);
        chk("last_status", st, last_status);
        chk("length", 0, {r[8], r[9], r[10], r[11]});
        chk("payload sum", 0, {r[58], r[59], r[60], r[61]});
        chk("header sum", i_kacf_host.crc16(r), {r[62], r[63]});
    endtask
    task t_alive;
        run(8'hFE, 0, 0, 16'h0000, 8'hA1, 64, 8'h00);
        run(8'hFE, 0, 0, 16'h0000, 8'hA1, 64, 8'h00);
    endtask
    task t_framing;
        run(8'hFE, 0, 0, 16'h0001, 8'hA1, 64, 8'hFB);
        run(8'hFE, 0, 0, 16'h0000, 8'hA0, 64, 8'hFB);
        run(8'hFE, 0, 0, 16'h0000, 8'hA1, 40, 8'hFB);
        i_kacf_host.protocol_revision_byte = 8'h04;
        run(8'hFE, 0, 0, 16'h0000, 8'hA1, 64, 8'hFB);
        i_kacf_host.protocol_revision_byte = 8'h03;
    endtask
    task t_unknown;
        run(8'h55, 0, 0, 16'h0000, 8'hA1, 64, 8'hFF);
    endtask
    task t_length;
        run(8'hFE, 1, 0, 16'h0000, 8'hA1, 64, 8'hFE);
        run(8'hFE, 0, 32'h1234, 16'h0000, 8'hA1, 64, 8'hFC);
        needs_payload = 1'b1;
        run(8'hFE, 0, 0, 16'h0000, 8'hA1, 64, 8'hFD);
        needs_payload = 1'b0;
    endtask
    task t_conds;
        logic [7:0] st [5];
        st = '{8'hFC, 8'hFA, 8'h11, 8'h0F, 8'h0D};
        for (int k = 0; k < 5; k++) begin
            cond = kacf_cond_type'(5'h01 << k);
            run(8'hFE, 0, 0, 16'h0000, 8'hA1, 64, st[k]);
        end
        cond = '0;
    endtask
    initial begin
        nrst = 1'b0;
        cond = '0;
        needs_payload = 1'b0;
        repeat (10) @(negedge clk_sys);
        nrst = 1'b1;
        chk("reset status", 8'h00, last_status);
        t_alive();
        t_framing();
        t_unknown();
        t_length();
        t_conds();
        end_sim();
    end
endmodule

/* File: pkg/kacf_pkg.sv */
package kacf_pkg;

    // frame layout, byte offsets within the 64-byte header
    localparam int KACF_HDR_BYTES    = 64;
    localparam int KACF_OFS_PRE_HI   = 8'h00;
    localparam int KACF_OFS_PRE_LO   = 8'h01;
    localparam int KACF_OFS_REV      = 8'h02;
    localparam int KACF_OFS_CMD      = 8'h03;
    localparam int KACF_OFS_SUBCMD   = 8'h04;
    localparam int KACF_OFS_STATUS   = 8'h05;
    localparam int KACF_OFS_FLAGS    = 8'h06;
    localparam int KACF_OFS_LEN      = 8'h08;
    localparam int KACF_OFS_AUX0     = 8'h0C;
    localparam int KACF_OFS_RSVD     = 8'h10;
    localparam int KACF_OFS_PCRC     = 8'h3A;
    localparam int KACF_OFS_HCRC     = 8'h3E;
    localparam int KACF_CRC_FIRST    = 8'h02;
    localparam int KACF_CRC_LAST     = 8'h3D;

    // constant field values
    localparam logic [15:0] KACF_PREAMBLE   = 16'hA1EC;
    localparam logic [7:0]  KACF_REVISION   = 8'h03;
    localparam logic [7:0]  KACF_CMD_ALIVE  = 8'hFE;
    localparam logic [15:0] KACF_CRC16_POLY = 16'h1021;
    localparam logic [15:0] KACF_CRC16_INIT = 16'h0000;
    localparam logic [31:0] KACF_CRC32_POLY = 32'h04C11DB7;
    localparam logic [31:0] KACF_CRC32_INIT = 32'h0FFFFFFF;

    // result codes
    localparam logic [7:0] KACF_ST_OK        = 8'h00;
    localparam logic [7:0] KACF_ST_HANDLE    = 8'h0D;
    localparam logic [7:0] KACF_ST_BAD_WRITE = 8'h0F;
    localparam logic [7:0] KACF_ST_BAD_READ  = 8'h10;
    localparam logic [7:0] KACF_ST_REG_END   = 8'h11;
    localparam logic [7:0] KACF_ST_TOO_LONG  = 8'hFA;
    localparam logic [7:0] KACF_ST_HCRC_ERR  = 8'hFB;
    localparam logic [7:0] KACF_ST_PCRC_ERR  = 8'hFC;
    localparam logic [7:0] KACF_ST_LEN_ZERO  = 8'hFD;
    localparam logic [7:0] KACF_ST_LEN_NZERO = 8'hFE;
    localparam logic [7:0] KACF_ST_UNKNOWN   = 8'hFF;

    // one byte of a frame stream with its handshake
    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } kacf_byte_type;

    // side conditions reported by the rest of the device
    typedef struct packed {
        logic bad_handle;
        logic bad_write;
        logic reg_end;
        logic too_long;
        logic pcrc_err;
    } kacf_cond_type;

endpackage

/* File: rtl/kacf_checker.sv */
`timescale 1ns/1ps
// Summary of operation
// - frames start with 0xA1EC, high byte first
// - offset 0x02 carries revision 0x03
// - alive command 0xFE echoed; unknown gives 0xFF
// - length and payload checksum are zero
// - header checksum over 0x02..0x3D; mismatch gives 0xFB
// - header checksum poly 0x1021, start zero
// - payload checksum mismatch reports 0xFC
// - flags field sent clear, ignored on receipt
// - illegal write reports 0x0F
// - bad read reports 0x11, not deprecated 0x10
// - oversize length reports 0xFA
// - payload command with zero length gives 0xFD
// - no-payload command with nonzero length gives 0xFE
module kacf_checker
    import kacf_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    input  wire kacf_byte_type rx_byte,
    output      logic          rx_ready,
    input  wire kacf_cond_type cond,
    input  wire logic          needs_payload,
    output      kacf_byte_type tx_byte,
    input  wire logic          tx_ready,
    output      logic          frame_done,
    output      logic [7:0]    last_status
);
    typedef enum {KACF_RECV, KACF_EVAL, KACF_SEND, KACF_CRC, KACF_TXCS} kacf_state_type;

    kacf_state_type state_ff, nxt_state;
    logic [5:0]     idx_ff, nxt_idx;
    logic [7:0]     cmd_ff, nxt_cmd;
    logic [7:0]     status_ff, nxt_status;
    logic [15:0]    rx_hcrc_ff, nxt_rx_hcrc;
    logic           len_nz_ff, nxt_len_nz;
    logic           pcrc_nz_ff, nxt_pcrc_nz;
    logic           pre_bad_ff, nxt_pre_bad;
    logic           rev_bad_ff, nxt_rev_bad;
    logic           short_ff, nxt_short;
    kacf_byte_type  tx_ff, nxt_tx;
    logic           done_ff, nxt_done;
    logic [15:0]    crc_val;
    logic           crc_clear;
    logic           crc_en;
    logic [7:0]     crc_data;
    logic [7:0]     rsp_byte;
    logic           rx_take;

    kacf_crc16 u_crc (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .clear   (crc_clear),
        .enable  (crc_en),
        .data    (crc_data),
        .crc     (crc_val)
    );

    assign rx_ready = (state_ff == KACF_RECV);
    assign rx_take  = rx_byte.valid && rx_ready;

    // response header byte for the current index, before its checksum
    always_comb begin
        case (idx_ff)
            6'(KACF_OFS_PRE_HI): rsp_byte = KACF_PREAMBLE[15:8];
            6'(KACF_OFS_PRE_LO): rsp_byte = KACF_PREAMBLE[7:0];
            6'(KACF_OFS_REV):    rsp_byte = KACF_REVISION;
            6'(KACF_OFS_CMD):    rsp_byte = cmd_ff;
            6'(KACF_OFS_STATUS): rsp_byte = status_ff;
            default:             rsp_byte = 8'h00;               // flags, length, payload crc zero
        endcase
    end

    // crc feed: receive bytes 0x02..0x3D, then response bytes likewise
    always_comb begin
        crc_clear = 1'b0;
        crc_en    = 1'b0;
        crc_data  = rsp_byte;
        if (state_ff == KACF_RECV) begin
            crc_data  = rx_byte.data;
            crc_clear = rx_take && (idx_ff == 6'(KACF_OFS_PRE_HI));
            crc_en    = rx_take && (idx_ff >= 6'(KACF_CRC_FIRST)) && (idx_ff <= 6'(KACF_CRC_LAST));
        end else if (state_ff == KACF_EVAL) begin
            crc_clear = 1'b1;
        end else if (state_ff == KACF_SEND) begin
            crc_en = (!tx_ff.valid || tx_ready) && (idx_ff >= 6'(KACF_CRC_FIRST))
                     && (idx_ff <= 6'(KACF_CRC_LAST));
        end
    end

    // frame sequencer
    always_comb begin
        nxt_state   = state_ff;
        nxt_idx     = idx_ff;
        nxt_cmd     = cmd_ff;
        nxt_status  = status_ff;
        nxt_rx_hcrc = rx_hcrc_ff;
        nxt_len_nz  = len_nz_ff;
        nxt_pcrc_nz = pcrc_nz_ff;
        nxt_pre_bad = pre_bad_ff;
        nxt_rev_bad = rev_bad_ff;
        nxt_short   = short_ff;
        nxt_tx      = tx_ff;
        nxt_done    = 1'b0;
        if (tx_ff.valid && tx_ready) begin
            nxt_tx.valid = 1'b0;
            nxt_tx.last  = 1'b0;
        end
        case (state_ff)
            KACF_RECV: begin
                if (rx_take) begin
                    nxt_idx = idx_ff + 6'd1;
                    if (idx_ff == 6'(KACF_OFS_PRE_HI)) begin
                        nxt_pre_bad = (rx_byte.data != KACF_PREAMBLE[15:8]);
                        nxt_rev_bad = 1'b0;
                        nxt_len_nz  = 1'b0;
                        nxt_pcrc_nz = 1'b0;
                        nxt_short   = 1'b0;
                    end
                    if (idx_ff == 6'(KACF_OFS_PRE_LO) && rx_byte.data != KACF_PREAMBLE[7:0]) begin
                        nxt_pre_bad = 1'b1;
                    end
                    if (idx_ff == 6'(KACF_OFS_REV)) begin
                        nxt_rev_bad = (rx_byte.data != KACF_REVISION);
                    end
                    if (idx_ff == 6'(KACF_OFS_CMD)) begin
                        nxt_cmd = rx_byte.data;
                    end
                    // subcommand, status, flags, aux and reserved bytes are not looked at
                    if (idx_ff >= 6'(KACF_OFS_LEN) && idx_ff < 6'(KACF_OFS_AUX0) && rx_byte.data != 8'h00) begin
                        nxt_len_nz = 1'b1;
                    end
                    if (idx_ff >= 6'(KACF_OFS_PCRC) && idx_ff < 6'(KACF_OFS_HCRC) && rx_byte.data != 8'h00) begin
                        nxt_pcrc_nz = 1'b1;
                    end
                    if (idx_ff == 6'(KACF_OFS_HCRC)) begin
                        nxt_rx_hcrc[15:8] = rx_byte.data;
                    end
                    if (idx_ff == 6'(KACF_HDR_BYTES - 1)) begin
                        nxt_rx_hcrc[7:0] = rx_byte.data;
                        nxt_state = KACF_EVAL;
                    end else if (rx_byte.last) begin
                        nxt_short = 1'b1; // truncated frame: treated as header mismatch
                        nxt_state = KACF_EVAL;
                    end
                end
            end
            KACF_EVAL: begin
                // priority: framing and checksum first, then command, then bad handle, then length, then the other side conditions
                if (short_ff || pre_bad_ff || rev_bad_ff || rx_hcrc_ff != crc_val) begin
                    nxt_status = KACF_ST_HCRC_ERR;
                end else if (cmd_ff != KACF_CMD_ALIVE) begin
                    nxt_status = KACF_ST_UNKNOWN;
                end else if (cond.bad_handle) begin
                    nxt_status = KACF_ST_HANDLE;
                end else if (needs_payload && !len_nz_ff) begin
                    nxt_status = KACF_ST_LEN_ZERO;
                end else if (!needs_payload && len_nz_ff) begin
                    nxt_status = KACF_ST_LEN_NZERO;
                end else if (cond.too_long) begin
                    nxt_status = KACF_ST_TOO_LONG;
                end else if (cond.pcrc_err || (!needs_payload && pcrc_nz_ff)) begin
                    nxt_status = KACF_ST_PCRC_ERR;
                end else if (cond.bad_write) begin
                    nxt_status = KACF_ST_BAD_WRITE;
                end else if (cond.reg_end) begin
                    nxt_status = KACF_ST_REG_END;  // deprecated 0x10 never issued
                end else begin
                    nxt_status = KACF_ST_OK;
                end
                nxt_idx   = 6'd0;
                nxt_state = KACF_SEND;
            end
            KACF_SEND: begin
                if (!tx_ff.valid || tx_ready) begin
                    nxt_tx.valid = 1'b1;
                    nxt_tx.last  = 1'b0;
                    nxt_tx.data  = rsp_byte;
                    nxt_idx      = idx_ff + 6'd1;
                    if (idx_ff == 6'(KACF_CRC_LAST)) begin
                        nxt_state = KACF_CRC;
                    end
                end
            end
            KACF_CRC: begin
                // checksum register settles one cycle after the last byte
                if (!tx_ff.valid || tx_ready) begin
                    nxt_tx.valid = 1'b1;
                    nxt_tx.last  = 1'b0;
                    nxt_tx.data  = crc_val[15:8];
                    nxt_state    = KACF_TXCS;
                end
            end
            KACF_TXCS: begin
                if (!tx_ff.valid || tx_ready) begin
                    nxt_tx.valid = 1'b1;
                    nxt_tx.last  = 1'b1;
                    nxt_tx.data  = crc_val[7:0];
                    nxt_idx      = 6'd0;
                    nxt_done     = 1'b1;
                    nxt_state    = KACF_RECV;
                end
            end
            default: begin
                nxt_state = KACF_RECV;
                nxt_idx   = 6'd0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_ff   <= KACF_RECV;
            idx_ff     <= 6'd0;
            cmd_ff     <= 8'h00;
            status_ff  <= KACF_ST_OK;
            rx_hcrc_ff <= 16'h0000;
            len_nz_ff  <= 1'b0;
            pcrc_nz_ff <= 1'b0;
            pre_bad_ff <= 1'b0;
            rev_bad_ff <= 1'b0;
            short_ff   <= 1'b0;
            tx_ff      <= '0;
            done_ff    <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            idx_ff     <= nxt_idx;
            cmd_ff     <= nxt_cmd;
            status_ff  <= nxt_status;
            rx_hcrc_ff <= nxt_rx_hcrc;
            len_nz_ff  <= nxt_len_nz;
            pcrc_nz_ff <= nxt_pcrc_nz;
            pre_bad_ff <= nxt_pre_bad;
            rev_bad_ff <= nxt_rev_bad;
            short_ff   <= nxt_short;
            tx_ff      <= nxt_tx;
            done_ff    <= nxt_done;
        end
    end

    assign tx_byte     = tx_ff;
    assign frame_done  = done_ff;
    assign last_status = status_ff;
endmodule

/* File: rtl/kacf_crc16.sv */
`timescale 1ns/1ps
// bytewise crc over the header, msb first, no reflection
module kacf_crc16
    import kacf_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        clear,
    input  wire logic        enable,
    input  wire logic [7:0]  data,
    output      logic [15:0] crc
);
    logic [15:0] crc_ff;
    logic [15:0] nxt_crc;

    // eight shift steps per byte; one byte per clock is ample for the link
    always_comb begin
        logic [15:0] c;
        c = crc_ff;
        for (int i = 7; i >= 0; i--) begin
            if (c[15] ^ data[i]) begin
                c = {c[14:0], 1'b0} ^ KACF_CRC16_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        if (clear) begin
            nxt_crc = KACF_CRC16_INIT;
        end else if (enable) begin
            nxt_crc = c;
        end else begin
            nxt_crc = crc_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            crc_ff <= KACF_CRC16_INIT;
        end else begin
            crc_ff <= nxt_crc;
        end
    end

    assign crc = crc_ff;
endmodule
